// ==== bench/mem_model.sv ====
// memory model answering the former's word reads
`timescale 1ns/1ps
module mem_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [1:0] lat,
    input wire logic memReq,
    input wire logic [15:0] memAddr,
    output logic memAck,
    output logic [15:0] memData
);
    logic [1:0] waitCnt;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            memAck <= 1'b0;
            waitCnt <= 2'h0;
            memData <= 16'h0000;
        end else if (memReq && !memAck && waitCnt == lat) begin
            memAck <= 1'b1;
            waitCnt <= 2'h0;
            memData <= memAddr ^ 16'h9c35;
        end else begin
            memAck <= 1'b0;
            waitCnt <= (memReq && !memAck) ? waitCnt + 2'h1 : 2'h0;
            memData <= ~memData;
        end
    end
endmodule

// ==== bench/mem_ref_ea_former_monitor.sv ====
// assertion checker for the effective-address former
`timescale 1ns/1ps
module mem_ref_ea_former_monitor (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [15:0] instr,
    input wire logic [15:0] pc,
    input ea_types_pkg::mode_t mode,
    input wire logic [15:0] stackPointer,
    input wire logic busy,
    input wire logic eaValid,
    input wire logic [15:0] ea,
    input wire logic eaRegister,
    input wire logic opcodeValid,
    input wire logic [8:0] opcodeField,
    input wire logic twoWord,
    input wire logic spWrite,
    input wire logic [15:0] spNext,
    input wire logic memReq,
    input wire logic [15:0] memAddr,
    input wire logic memAck
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire go = start && !busy && instr[15:14] == 2'b00;
    wire rel = mode == ea_types_pkg::MODE_R32 || mode == ea_types_pkg::MODE_R64;
    wire sec = mode == ea_types_pkg::MODE_S16 || mode == ea_types_pkg::MODE_S32;
    wire esc = rel && instr[9:4] == 6'h30;
    function automatic logic [15:0] msk(input ea_types_pkg::mode_t m);
        return m == ea_types_pkg::MODE_S16 ? 16'h3fff : (m == ea_types_pkg::MODE_R64 ? 16'hffff : 16'h7fff);
    endfunction
    // ----------------------------------------
    // address results
    // ----------------------------------------
    property p_basic;
        go && !instr[9] && mode != ea_types_pkg::MODE_V64 |=> eaValid && ea == {7'h00, $past(instr[8:0])}
            && eaRegister == ($past(instr[8:0]) < 9'h008);
    endproperty
    a_basic: assert property (p_basic) else $error("basic address wrong");
    property p_sector;
        go && instr[9] && sec |=> eaValid && ea == ({$past(pc[15:9]), $past(instr[8:0])} & msk($past(mode)));
    endproperty
    a_sector: assert property (p_sector) else $error("sector address wrong");
    property p_procrel;
        go && instr[9] && !instr[8] && rel |=> eaValid
            && ea == (($past(pc) + 16'h0001 + {7'h00, $past(instr[8:0])}) & msk($past(mode)));
    endproperty
    a_procrel: assert property (p_procrel) else $error("relative address wrong");
    property p_opcode;
        go && instr[9:0] == 10'h310 && rel |=> opcodeValid && opcodeField == 9'h110 && !eaValid;
    endproperty
    a_opcode: assert property (p_opcode) else $error("operation code not flagged");
    property p_post;
        go && esc && instr[1:0] == 2'h2 |=> spWrite && spNext == $past(stackPointer) + 16'h0001 && !memReq
            && eaValid && !twoWord && ea == ($past(stackPointer) & msk($past(mode)));
    endproperty
    a_post: assert property (p_post) else $error("postincrement wrong");
    property p_long;
        go && esc && instr[1:0] == 2'h0 |=> ##1 memReq && busy && twoWord && memAddr == $past(pc, 2) + 16'h0001;
    endproperty
    a_long: assert property (p_long) else $error("address word not fetched");
    // ----------------------------------------
    // fetch handshake
    // ----------------------------------------
    property p_hold;
        memReq && !memAck |=> memReq && busy && $stable(memAddr);
    endproperty
    a_hold: assert property (p_hold) else $error("read dropped early");
    property p_gap;
        memReq && memAck |=> !memReq && !eaValid;
    endproperty
    a_gap: assert property (p_gap) else $error("read not released");
endmodule
bind mem_ref_ea_former mem_ref_ea_former_monitor u_mem_ref_ea_former_monitor (.clk_sys(clk_sys), .rst_b(rst_b),
    .start(start), .instr(instr), .pc(pc), .mode(mode), .stackPointer(stackPointer), .busy(busy),
    .eaValid(eaValid), .ea(ea), .eaRegister(eaRegister), .opcodeValid(opcodeValid), .opcodeField(opcodeField),
    .spWrite(spWrite), .spNext(spNext), .memReq(memReq), .memAddr(memAddr), .memAck(memAck), .twoWord(twoWord));

// ==== bench/tb.sv ====
// self-checking bench for the effective-address former
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic start = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [15:0] pc = 16'h0000;
    ea_types_pkg::mode_t mode = ea_types_pkg::MODE_S16;
    logic [15:0] indexX = 16'h0000;
    logic [15:0] stackPointer = 16'h0000;
    logic [15:0] stackBase = 16'h0000;
    logic [15:0] linkBase = 16'h0000;
    logic [15:0] procedureBase = 16'h0000;
    logic [1:0] lat = 2'h0;
    logic busy, eaValid, eaRegister, opcodeValid, memReq, memAck, eaProcSeg, unsupported;
    logic [15:0] ea, memAddr, memData;
    logic [8:0] opcodeField;
    logic [17:0] expq[$];
    logic [17:0] got;
    logic [17:0] seen;
    logic [15:0] rs = 16'hdaca;
    int n_fail = 0;
    int checks_done = 0;
    always #50 clk_sys = ~clk_sys;
    mem_ref_ea_former u_mem_ref_ea_former (.clk_sys(clk_sys), .rst_b(rst_b), .start(start), .instr(instr),
        .pc(pc), .mode(mode), .indexX(indexX), .stackPointer(stackPointer), .stackBase(stackBase),
        .linkBase(linkBase), .procedureBase(procedureBase), .busy(busy), .eaValid(eaValid), .ea(ea),
        .eaRegister(eaRegister), .eaProcSeg(eaProcSeg), .twoWord(), .unsupported(unsupported),
        .opcodeValid(opcodeValid),
        .opcodeField(opcodeField), .spWrite(), .spNext(), .memReq(memReq), .memAddr(memAddr),
        .memRegister(), .memAck(memAck), .memData(memData));
    mem_model u_mem_model (.clk_sys(clk_sys), .rst_b(rst_b), .lat(lat), .memReq(memReq), .memAddr(memAddr),
        .memAck(memAck), .memData(memData));
    function automatic logic [15:0] rnd();
        rs ^= rs << 7;
        rs ^= rs >> 9;
        rs ^= rs << 8;
        return rs;
    endfunction
    function automatic logic [15:0] mw(input logic [15:0] a);
        return a ^ 16'h9c35;
    endfunction
    function automatic logic [15:0] mk(input int mi);
        return mi == 0 ? 16'h3fff : (mi < 3 ? 16'h7fff : 16'hffff);
    endfunction
    task automatic finish_test();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic go(input logic [15:0] i, input logic [15:0] p, input int mi, input logic [17:0] e);
        expq.push_back(e);
        while (busy !== 1'b0) @(negedge clk_sys);
        start = 1'b1;
        instr = i;
        pc = p;
        mode = ea_types_pkg::mode_t'(mi);
        lat = rs[1:0];
        @(negedge clk_sys);
    endtask
    task automatic tend(input string s);
        start = 1'b0;
        while (expq.size() != 0) @(negedge clk_sys);
        @(negedge clk_sys);
        $display("test %s done", s);
    endtask
    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(negedge clk_sys) begin
        if (rst_b && (eaValid === 1'b1 || opcodeValid === 1'b1 || unsupported === 1'b1)) begin
            got = expq.size() != 0 ? expq.pop_front() : 18'h3ffff;
            seen = eaValid ? {eaProcSeg, eaRegister, ea} : {2'b11, opcodeValid ? {7'h00, opcodeField} : 16'h8000};
            `CHK("result", got, seen)
        end
    end
    initial begin
        #400000;
        n_fail++;
        finish_test();
    end
    initial begin
        logic [15:0] r, p, a;
        logic [8:0] d;
        logic [8:0] dl[6] = '{9'h000, 9'h0ff, 9'h110, 9'h111, 9'h121, 9'h1ff};
        repeat (16) @(negedge clk_sys);
        rst_b = 1'b1;
        indexX = rnd();
        stackPointer = rnd();
        stackBase = rnd();
        linkBase = rnd();
        procedureBase = rnd();
        for (int k = 0; k < 16; k++) begin
            r = rnd();
            p = rnd();
            d = k < 4 ? {6'h00, r[2:0]} : r[8:0];
            go({2'b00, r[13:10], 1'b0, d}, p, k % 4, {1'b0, d < 9'h008, 7'h00, d});
            go({2'b00, r[13:10], 1'b1, d}, p, k % 2, {2'b00, {p[15:9], d} & mk(k % 2)});
            d = d | 9'h008;
            go({2'b00, r[13:10], 1'b0, d}, p, 4, {2'b00, (d[8] ? linkBase : stackBase) + {7'h00, d}});
        end
        tend("direct");
        for (int k = 0; k < 18; k++) begin
            p = rnd();
            d = dl[k % 6];
            if (d == 9'h110 || (k >= 12 && d[8] && d <= 9'h120))
                go({2'b00, p[3:0], 1'b1, d}, p, k / 6 + 2, {2'b11, 7'h00, d});
            else
                go({2'b00, p[3:0], 1'b1, d}, p, k / 6 + 2, {2'b00, (p + 16'h0001 + {{7{d[8]}}, d}) & mk(k / 6 + 2)});
        end
        for (int k = 0; k < 4; k++) begin
            r = rnd();
            go({2'b00, r[3:0], 6'h30, r[5:4], 1'b1, k[0]}, r, 2 + k / 2,
                {2'b00, (stackPointer - {15'h0000, k[0]}) & mk(2 + k / 2)});
        end
        tend("relative");
        r = rnd();
        p = {2'b00, r[13:0]};
        a = mw(p + 16'h0001);
        go({2'h0, r[3:0], 10'h300}, p, 2, {2'b00, a & 16'h7fff});
        go({2'h0, r[3:0], 10'h300}, p, 3, {2'b00, a});
        go({2'h1, r[3:0], 10'h300}, p, 3, {2'b00, a + indexX});
        go({2'h2, r[3:0], 10'h300}, p, 3, {2'b00, mw(a)});
        go({2'h3, r[3:0], 10'h300}, p, 3, {2'b00, mw(a + indexX)});
        go({2'h3, r[3:0], 10'h302}, p, 3, {2'b00, mw(a) + indexX});
        go({2'h3, r[3:0], 1'b0, 9'h03f}, p, 3, {2'b00, mw(16'h003f + indexX)});
        go({2'h3, r[3:0], 1'b0, 9'h040}, p, 3, {2'b00, mw(16'h0040) + indexX});
        go({2'h3, r[3:0], 1'b1, 9'h005}, p, 3, {2'b00, mw(p + 16'h0006) + indexX});
        go({2'h0, r[3:0], 10'h301}, p, 3, 18'h38000);
        go({2'h2, r[3:0], 1'b0, 9'h010}, p, 4, {2'b10, mw(procedureBase + 16'h0010)});
        go({2'h2, r[3:0], 1'b0, 9'h005}, p, 4, {2'b10, mw(16'h0005)});
        tend("fetch");
        finish_test();
    end
endmodule

// ==== logic/ea_former_regs.svh ====
// field positions, limits and masks for the effective-address former
`ifndef EA_FORMER_REGS_SVH
`define EA_FORMER_REGS_SVH
`define IND_BIT 15
`define IDX_BIT 14
`define SECT_BIT 9
`define DISP_HI 8
`define DISP_LO 0
`define SIGN_BIT 8
`define ESC_HI 9
`define ESC_LO 4
`define ESC_CODE 6'h30
`define CLASS_HI 1
`define CLASS_LO 0
`define PCSECT_HI 15
`define PCSECT_LO 9
`define CB_LONG 2'h0
`define CB_STKREL 2'h1
`define CB_POST 2'h2
`define CB_PRE 2'h3
`define REG_LIMIT 9'h008
`define REG_LIMIT16 16'h0008
`define PREIDX_MAX 9'h03f
`define SB_MAX 9'h0ff
`define R_CODE_MAX 9'h110
`define V_CODE_MAX 9'h120
`define MASK_14 16'h3fff
`define MASK_15 16'h7fff
`define MASK_16 16'hffff
`define PTR_IND_BIT 15
`define PTR_IDX_BIT 14
`define WORD_STEP 16'h0001
`define ZERO16 16'h0000
`define ZERO9 9'h000
`endif

// ==== logic/ea_types_pkg.sv ====
// types shared by the effective-address former modules
package ea_types_pkg;
    typedef enum logic [2:0] {MODE_S16, MODE_S32, MODE_R32, MODE_R64, MODE_V64} mode_t;
    typedef enum logic [3:0] {
        CL_BASIC, CL_SECTOR, CL_PROCREL, CL_STACK_POST, CL_STACK_PRE,
        CL_BASEREG, CL_LONG, CL_STACKREL, CL_OPCODE
    } class_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ADDRWORD, ST_POINTER} state_t;
endpackage

// ==== logic/field_decoder.sv ====
// instruction field and address class decoder
`timescale 1ns/1ps
`include "ea_former_regs.svh"
module field_decoder (
    input wire logic [15:0] instr,
    input ea_types_pkg::mode_t mode,
    output ea_types_pkg::class_t cls,
    output logic [8:0] disp,
    output logic indirect,
    output logic indexed,
    output logic sector
);
    logic relative;
    logic isCode;
    logic [8:0] codeMax;
    logic [1:0] classSel;

    always_comb begin
        indirect = instr[`IND_BIT];
        indexed = instr[`IDX_BIT];
        sector = instr[`SECT_BIT];
        disp = instr[`DISP_HI:`DISP_LO];
        classSel = instr[`CLASS_HI:`CLASS_LO];
        relative = (mode == ea_types_pkg::MODE_R32) || (mode == ea_types_pkg::MODE_R64) ||
                   (mode == ea_types_pkg::MODE_V64);
        codeMax = (mode == ea_types_pkg::MODE_V64) ? `V_CODE_MAX : `R_CODE_MAX;
        isCode = sector && relative && disp[`SIGN_BIT] && (disp <= codeMax);
        if (!sector) begin
            cls = (mode == ea_types_pkg::MODE_V64) ? ea_types_pkg::CL_BASEREG : ea_types_pkg::CL_BASIC;
        end else if (!relative) begin
            cls = ea_types_pkg::CL_SECTOR;
        end else if (!isCode) begin
            cls = ea_types_pkg::CL_PROCREL;
        end else if (mode != ea_types_pkg::MODE_V64 && instr[`ESC_HI:`ESC_LO] == `ESC_CODE) begin
            unique case (classSel)
                `CB_LONG: cls = ea_types_pkg::CL_LONG;
                `CB_STKREL: cls = ea_types_pkg::CL_STACKREL;
                `CB_POST: cls = (indirect && indexed) ? ea_types_pkg::CL_LONG : ea_types_pkg::CL_STACK_POST;
                `CB_PRE: cls = (indirect && indexed) ? ea_types_pkg::CL_STACKREL : ea_types_pkg::CL_STACK_PRE;
            endcase
        end else begin
            cls = ea_types_pkg::CL_OPCODE;
        end
    end
endmodule

// ==== logic/mem_port_if.sv ====
// word fetch request and answer between sequencer and fetcher
`timescale 1ns/1ps
interface mem_port_if;
    logic fetchStart;
    logic [15:0] fetchAddr;
    logic fetchReg;
    logic fetchDone;
    logic [15:0] fetchData;
    modport seq (output fetchStart, output fetchAddr, output fetchReg, input fetchDone, input fetchData);
    modport fetch (input fetchStart, input fetchAddr, input fetchReg, output fetchDone, output fetchData);
endinterface

// ==== logic/mem_ref_ea_former.sv ====
// effective-address former for one- and two-word memory reference instructions
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
`include "ea_former_regs.svh"
module mem_ref_ea_former (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [15:0] instr,
    input wire logic [15:0] pc,
    input ea_types_pkg::mode_t mode,
    input wire logic [15:0] indexX,
    input wire logic [15:0] stackPointer,
    input wire logic [15:0] stackBase,
    input wire logic [15:0] linkBase,
    input wire logic [15:0] procedureBase,
    output logic busy,
    output logic eaValid,
    output logic [15:0] ea,
    output logic eaRegister,
    output logic eaProcSeg,
    output logic twoWord,
    output logic unsupported,
    output logic opcodeValid,
    output logic [8:0] opcodeField,
    output logic spWrite,
    output logic [15:0] spNext,
    output logic memReq,
    output logic [15:0] memAddr,
    output logic memRegister,
    input wire logic memAck,
    input wire logic [15:0] memData
);
    // ----------------------------------------
    // decode and fetch path
    // ----------------------------------------
    ea_types_pkg::class_t decCls;
    logic [8:0] decDisp;
    logic decInd;
    logic decIdx;
    logic decSect;
    ea_types_pkg::state_t state;
    ea_types_pkg::state_t next_state;
    mem_port_if mp ();

    field_decoder u_decoder (
        .instr(instr),
        .mode(mode),
        .cls(decCls),
        .disp(decDisp),
        .indirect(decInd),
        .indexed(decIdx),
        .sector(decSect)
    );

    word_fetcher u_fetcher (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .port(mp.fetch),
        .memReq(memReq),
        .memAddr(memAddr),
        .memRegister(memRegister),
        .memAck(memAck),
        .memData(memData)
    );

    // ----------------------------------------
    // mode width truncation
    // ----------------------------------------
    function automatic logic [15:0] trunc(input ea_types_pkg::mode_t m, input logic [15:0] v);
        logic [15:0] r;
        r = v & `MASK_16;
        unique case (m)
            ea_types_pkg::MODE_S16: r = v & `MASK_14;
            ea_types_pkg::MODE_S32: r = v & `MASK_15;
            ea_types_pkg::MODE_R32: r = v & `MASK_15;
            ea_types_pkg::MODE_R64: r = v;
            ea_types_pkg::MODE_V64: r = v;
        endcase
        return r;
    endfunction

    // ----------------------------------------
    // first step of address formation
    // ----------------------------------------
    logic [15:0] dz;
    logic [15:0] dsx;
    logic [15:0] xOff;
    logic [15:0] base;
    logic [15:0] sAddr;
    logic sFetch;
    logic sPost;
    logic sRegRef;
    logic sRegPtr;
    logic sProc;

    always_comb begin
        dz = {7'h00, decDisp};
        dsx = {{7{decDisp[`SIGN_BIT]}}, decDisp};
        xOff = decIdx ? indexX : `ZERO16;
        base = `ZERO16;
        sAddr = `ZERO16;
        sFetch = 1'b0;
        sPost = 1'b0;
        sRegRef = 1'b0;
        sRegPtr = 1'b0;
        sProc = 1'b0;
        unique case (decCls)
            ea_types_pkg::CL_BASIC: begin
                base = dz;
                if (decInd) begin
                    sFetch = 1'b1;
                    if (decIdx && mode != ea_types_pkg::MODE_S16 && decDisp > `PREIDX_MAX) begin
                        sPost = 1'b1;
                        sAddr = base;
                    end else begin
                        sAddr = base + xOff;
                    end
                end else begin
                    sAddr = base + xOff;
                    sRegRef = !decIdx && (decDisp < `REG_LIMIT);
                end
            end
            ea_types_pkg::CL_SECTOR: begin
                base = {pc[`PCSECT_HI:`PCSECT_LO], decDisp};
                if (decInd) begin
                    sFetch = 1'b1;
                    sPost = decIdx && (mode == ea_types_pkg::MODE_S32);
                    sAddr = sPost ? base : base + xOff;
                end else begin
                    sAddr = base + xOff;
                end
            end
            ea_types_pkg::CL_PROCREL: begin
                base = pc + `WORD_STEP + dsx;
                sFetch = decInd;
                sPost = decInd && decIdx;
                sAddr = decInd ? base : base + xOff;
            end
            ea_types_pkg::CL_STACK_POST, ea_types_pkg::CL_STACK_PRE: begin
                base = (decCls == ea_types_pkg::CL_STACK_PRE) ? stackPointer - `WORD_STEP : stackPointer;
                sFetch = decInd || decIdx;
                sPost = decIdx;
                sAddr = base;
            end
            ea_types_pkg::CL_BASEREG: begin
                sProc = decInd;
                if (!decInd) begin
                    if (decDisp <= `SB_MAX) begin
                        base = dz + xOff;
                        sRegRef = base < `REG_LIMIT16;
                        sAddr = sRegRef ? base : stackBase + base;
                    end else begin
                        sAddr = linkBase + dz + xOff;
                    end
                end else if (!decIdx && decDisp < `REG_LIMIT) begin
                    sFetch = 1'b1;
                    sRegPtr = 1'b1;
                    sAddr = dz;
                end else begin
                    sFetch = 1'b1;
                    sPost = decIdx && (decDisp > `PREIDX_MAX);
                    sAddr = procedureBase + (sPost ? dz : dz + xOff);
                end
            end
            ea_types_pkg::CL_LONG: begin
                sAddr = pc + `WORD_STEP;
            end
            ea_types_pkg::CL_STACKREL, ea_types_pkg::CL_OPCODE: begin
                sAddr = `ZERO16;
            end
        endcase
    end

    // ----------------------------------------
    // latched context for later steps
    // ----------------------------------------
    ea_types_pkg::mode_t ctxMode;
    logic [15:0] ctxX;
    logic ctxInd;
    logic ctxIdx;
    logic ctxPost;
    logic ctxLongPost;
    logic ctxProc;
    logic [15:0] addrWord;
    logic [15:0] ptrNext;
    logic ptrChain;

    always_comb begin
        addrWord = (ctxMode == ea_types_pkg::MODE_R32) ? mp.fetchData & `MASK_15 : mp.fetchData;
        ptrChain = mp.fetchData[`PTR_IND_BIT] && (ctxMode == ea_types_pkg::MODE_S16 ||
                   ctxMode == ea_types_pkg::MODE_S32 || ctxMode == ea_types_pkg::MODE_R32);
        ptrNext = trunc(ctxMode, (ctxMode == ea_types_pkg::MODE_S16 && mp.fetchData[`PTR_IDX_BIT]) ?
                  mp.fetchData + ctxX : mp.fetchData);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctxMode <= ea_types_pkg::MODE_S16;
            ctxX <= `ZERO16;
            ctxInd <= 1'b0;
            ctxIdx <= 1'b0;
            ctxPost <= 1'b0;
            ctxLongPost <= 1'b0;
            ctxProc <= 1'b0;
        end else if (state == ea_types_pkg::ST_IDLE && start) begin
            ctxMode <= mode;
            ctxX <= indexX;
            ctxInd <= decInd;
            ctxIdx <= decIdx;
            ctxPost <= sPost;
            ctxLongPost <= instr[`CLASS_HI:`CLASS_LO] == `CB_POST;
            ctxProc <= sProc;
        end else if (state == ea_types_pkg::ST_ADDRWORD && mp.fetchDone) begin
            ctxPost <= ctxLongPost;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ea_types_pkg::ST_IDLE: begin
                if (start) begin
                    if (decCls == ea_types_pkg::CL_LONG) begin
                        next_state = ea_types_pkg::ST_ADDRWORD;
                    end else if (sFetch) begin
                        next_state = ea_types_pkg::ST_POINTER;
                    end
                end
            end
            ea_types_pkg::ST_ADDRWORD: begin
                if (mp.fetchDone) begin
                    next_state = ctxInd ? ea_types_pkg::ST_POINTER : ea_types_pkg::ST_IDLE;
                end
            end
            ea_types_pkg::ST_POINTER: begin
                if (mp.fetchDone && !ptrChain) begin
                    next_state = ea_types_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= ea_types_pkg::ST_IDLE;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            busy <= next_state != ea_types_pkg::ST_IDLE;
        end
    end

    // ----------------------------------------
    // word fetch requests
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mp.fetchStart <= 1'b0;
            mp.fetchAddr <= `ZERO16;
            mp.fetchReg <= 1'b0;
        end else begin
            mp.fetchStart <= 1'b0;
            if (state == ea_types_pkg::ST_IDLE && start && (sFetch || decCls == ea_types_pkg::CL_LONG)) begin
                mp.fetchStart <= 1'b1;
                mp.fetchAddr <= (decCls == ea_types_pkg::CL_LONG) ? sAddr : trunc(mode, sAddr);
                mp.fetchReg <= sRegPtr;
            end else if (state == ea_types_pkg::ST_ADDRWORD && mp.fetchDone && ctxInd) begin
                mp.fetchStart <= 1'b1;
                mp.fetchAddr <= trunc(ctxMode, (ctxIdx && !ctxLongPost) ? addrWord + ctxX : addrWord);
                mp.fetchReg <= 1'b0;
            end else if (state == ea_types_pkg::ST_POINTER && mp.fetchDone && ptrChain) begin
                mp.fetchStart <= 1'b1;
                mp.fetchAddr <= ptrNext;
                mp.fetchReg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // final address
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            eaValid <= 1'b0;
            ea <= `ZERO16;
            eaRegister <= 1'b0;
            eaProcSeg <= 1'b0;
            twoWord <= 1'b0;
            unsupported <= 1'b0;
        end else begin
            eaValid <= 1'b0;
            unsupported <= 1'b0;
            if (state == ea_types_pkg::ST_IDLE && start) begin
                twoWord <= decCls == ea_types_pkg::CL_LONG || decCls == ea_types_pkg::CL_STACKREL;
                eaRegister <= 1'b0;
                eaProcSeg <= 1'b0;
                if (decCls == ea_types_pkg::CL_STACKREL) begin
                    unsupported <= 1'b1;
                end else if (decCls != ea_types_pkg::CL_OPCODE && decCls != ea_types_pkg::CL_LONG && !sFetch) begin
                    eaValid <= 1'b1;
                    ea <= trunc(mode, sAddr);
                    eaRegister <= sRegRef;
                end
            end else if (state == ea_types_pkg::ST_ADDRWORD && mp.fetchDone && !ctxInd) begin
                eaValid <= 1'b1;
                ea <= trunc(ctxMode, ctxIdx ? addrWord + ctxX : addrWord);
            end else if (state == ea_types_pkg::ST_POINTER && mp.fetchDone && !ptrChain) begin
                eaValid <= 1'b1;
                ea <= trunc(ctxMode, ctxPost ? mp.fetchData + ctxX : mp.fetchData);
                eaProcSeg <= ctxProc;
            end
        end
    end

    // ----------------------------------------
    // stack pointer update and operation codes
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            spWrite <= 1'b0;
            spNext <= `ZERO16;
        end else begin
            spWrite <= 1'b0;
            if (state == ea_types_pkg::ST_IDLE && start) begin
                if (decCls == ea_types_pkg::CL_STACK_POST) begin
                    spWrite <= 1'b1;
                    spNext <= stackPointer + `WORD_STEP;
                end else if (decCls == ea_types_pkg::CL_STACK_PRE) begin
                    spWrite <= 1'b1;
                    spNext <= stackPointer - `WORD_STEP;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            opcodeValid <= 1'b0;
            opcodeField <= `ZERO9;
        end else begin
            opcodeValid <= state == ea_types_pkg::ST_IDLE && start && decCls == ea_types_pkg::CL_OPCODE;
            if (state == ea_types_pkg::ST_IDLE && start && decCls == ea_types_pkg::CL_OPCODE) begin
                opcodeField <= decDisp;
            end
        end
    end
endmodule

// ==== logic/word_fetcher.sv ====
// single word memory read handshake
`timescale 1ns/1ps
module word_fetcher (
    input wire logic clk_sys,
    input wire logic rst_b,
    mem_port_if.fetch port,
    output logic memReq,
    output logic [15:0] memAddr,
    output logic memRegister,
    input wire logic memAck,
    input wire logic [15:0] memData
);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            memReq <= 1'b0;
            memAddr <= 16'h0000;
            memRegister <= 1'b0;
        end else if (port.fetchStart) begin
            memReq <= 1'b1;
            memAddr <= port.fetchAddr;
            memRegister <= port.fetchReg;
        end else if (memReq && memAck) begin
            memReq <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            port.fetchDone <= 1'b0;
            port.fetchData <= 16'h0000;
        end else begin
            port.fetchDone <= memReq && memAck;
            if (memReq && memAck) begin
                port.fetchData <= memData;
            end
        end
    end
endmodule
